/* File: hdl/mcpc_top.sv */
/*
 Power sequencing, master/subordinate role, chain clock and sync,
 and shared flag line control for one chassis system module.
 Assumes a 250 MHz core clock, synchronous active-high reset, and a
 register port with read data one cycle after the read strobe.
*/
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Local button press notifies every linked chassis to power on.
// - Notified chassis powers on and asserts not-ready toward others.
// - Master if embedded controller present or first host port unconnected.
// - Subordinate releases not-ready after modules active; master waits all.
// - Master waits configurable startup delay after everyone is ready.
// - Master boots embedded controller only after the startup delay.
// - Master first port is upstream to subordinate one; second to two.
// - Master sources shared 100 MHz clock, hop delay calibrated out; the clock path here has no hop delay compensation.
// - Master sources shared sync, hop delay calibrated the same way.
// - Subordinate detects chain cable, switches to cable clock.
// - Four bidirectional flag lines, each a trigger destination or source.
// - At most one driving source per flag across the chain.
// - Flag settable to static 1, static 0, or selected source.
// - Only one chassis drives chain sync; its sync forwarded downstream; here CTL_SYNC_DRIVE picks the source and there is no outbound sync port.
module mcpc_top
	import mcpc_pkg::*;
#(
	parameter logic [31:0] STARTUP_DELAY_CYC = STARTUP_DELAY_CYC_DEF
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output logic IRQ,
	input wire logic POWER_BUTTON,
	input wire logic POWER_REQ_IN,
	output logic POWER_REQ_OUT,
	output logic POWER_ON,
	input wire logic PEER_NOT_READY_IN,
	output logic NOT_READY_OUT,
	input wire logic MODULES_ACTIVE,
	input wire logic EMBEDDED_CTRL_PRESENT,
	input wire logic HOST_PORT1_CONNECTED,
	output logic PORT1_UPSTREAM,
	output logic PORT2_DOWNSTREAM,
	output logic CTRL_BOOT,
	output logic STATUS_STEADY,
	input wire logic INBOUND_CHAIN_CLOCK,
	input wire logic INBOUND_CHAIN_SYNC,
	input wire logic CABLE_PRESENT,
	output logic OUTBOUND_CHAIN_CLOCK,
	output logic OUTBOUND_CHAIN_RUN,
	output logic CLOCK_FROM_CABLE,
	input wire logic LOCAL_SYNC,
	output logic CHASSIS_SYNC,
	input wire logic [FLAG_COUNT-1:0] INBOUND_CHAIN_FLAG,
	output logic [FLAG_COUNT-1:0] FLAG_OUT,
	output logic [FLAG_COUNT-1:0] FLAG_OE,
	input wire logic [FLAG_COUNT-1:0] FLAG_SOURCE,
	input wire logic [FLAG_COUNT-1:0] FLAG_OTHER_DRIVER,
	output logic [FLAG_COUNT-1:0] FLAG_TO_TRIGGER
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	localparam int NSYNC = 9 + 2 * FLAG_COUNT;
	logic [NSYNC-1:0] pin_raw, pin_s;
	assign pin_raw = {INBOUND_CHAIN_FLAG, FLAG_OTHER_DRIVER,
		POWER_BUTTON, POWER_REQ_IN, PEER_NOT_READY_IN, MODULES_ACTIVE,
		EMBEDDED_CTRL_PRESENT, HOST_PORT1_CONNECTED, INBOUND_CHAIN_CLOCK,
		INBOUND_CHAIN_SYNC, CABLE_PRESENT};
	mcpc_sync2 #(.WIDTH(NSYNC)) u_sync (
		.clk(CORE_CLK),
		.rst(RST),
		.d(pin_raw),
		.q(pin_s)
	);
	wire [FLAG_COUNT-1:0] in_flag_s = pin_s[NSYNC-1 -: FLAG_COUNT];
	wire [FLAG_COUNT-1:0] other_drv_s = pin_s[9 +: FLAG_COUNT];
	wire button_s = pin_s[8];
	wire req_in_s = pin_s[7];
	wire peer_nr_s = pin_s[6];
	wire mod_active_s = pin_s[5];
	wire emb_s = pin_s[4];
	wire port1_s = pin_s[3];
	wire in_clk_s = pin_s[2];
	wire in_sync_s = pin_s[1];
	wire cable_s = pin_s[0];

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [31:0] control_r, delay_r;
	logic [7:0] flag_cfg_r;
	logic [5:0] hop_r;
	logic [EV_COUNT-1:0] event_r, mask_r, ev_set;
	logic [31:0] rdata_nxt;
	wire wr_ctl = WR && ADDR == REG_CONTROL;
	wire wr_dly = WR && ADDR == REG_DELAY;
	wire wr_flag = WR && ADDR == REG_FLAG_CFG;
	wire wr_ev = WR && ADDR == REG_EVENT;
	wire wr_mask = WR && ADDR == REG_MASK;
	wire wr_hop = WR && ADDR == REG_HOP;
	wire sync_drive = control_r[CTL_SYNC_DRIVE];
	wire [EV_COUNT-1:0] ev_clr = wr_ev ? WDATA[EV_COUNT-1:0] : '0;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			control_r <= CONTROL_RST;
			delay_r <= STARTUP_DELAY_CYC;
			flag_cfg_r <= FLAG_CFG_RST;
			hop_r <= HOP_DELAY_CYC_DEF;
			mask_r <= MASK_RST;
			event_r <= '0;
			RDATA <= 32'h0000_0000;
		end else begin
			if (wr_ctl) control_r <= WDATA;
			else control_r[CTL_SW_POWER] <= 1'b0;
			if (wr_dly) delay_r <= WDATA;
			if (wr_flag) flag_cfg_r <= WDATA[7:0];
			if (wr_hop) hop_r <= WDATA[5:0];
			if (wr_mask) mask_r <= WDATA[EV_COUNT-1:0];
			// Set wins over write-one-to-clear
			event_r <= (event_r & ~ev_clr) | ev_set;
			RDATA <= RD ? rdata_nxt : 32'h0000_0000;
		end
	end
	assign IRQ = |(event_r & mask_r);

	////////////////////////////////////////////////////////////////////
	// Power sequencing
	typedef enum logic [2:0] {ST_OFF, ST_NOT_READY, ST_WAIT_PEERS,
		ST_DELAY, ST_RUN} mcpc_state_t;
	mcpc_state_t state_r, state_nxt;
	logic [31:0] dly_cnt_r;
	logic [11:0] deb_cnt_r;
	logic press_r, is_master_r;
	wire sw_power = wr_ctl && WDATA[CTL_SW_POWER];
	wire sw_off = control_r[CTL_SW_OFF];
	wire press = press_r || sw_power;
	wire power_wake = press || req_in_s;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF: if (power_wake) state_nxt = ST_NOT_READY;
			ST_NOT_READY: if (mod_active_s) state_nxt = ST_WAIT_PEERS;
			ST_WAIT_PEERS: if (is_master_r && !peer_nr_s)
				state_nxt = ST_DELAY;
				else if (!is_master_r) state_nxt = ST_RUN;
			ST_DELAY: if (peer_nr_s) state_nxt = ST_WAIT_PEERS;
				else if (dly_cnt_r >= delay_r) state_nxt = ST_RUN;
			ST_RUN: state_nxt = ST_RUN;
			default: state_nxt = ST_OFF;
		endcase
		if (sw_off) state_nxt = ST_OFF;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_r <= ST_OFF;
			dly_cnt_r <= 32'h0000_0000;
			deb_cnt_r <= 12'h000;
			press_r <= 1'b0;
			is_master_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dly_cnt_r <= state_r == ST_DELAY ? dly_cnt_r + 32'h1 : 32'h0;
			deb_cnt_r <= button_s ? (deb_cnt_r == BUTTON_DEBOUNCE_CYC ?
				deb_cnt_r : deb_cnt_r + 12'h001) : 12'h000;
			press_r <= button_s && deb_cnt_r == BUTTON_DEBOUNCE_CYC - 12'h001;
			if (state_r == ST_NOT_READY)
				is_master_r <= emb_s || !port1_s;
		end
	end

	wire powered = state_r != ST_OFF;
	assign POWER_ON = powered;
	assign POWER_REQ_OUT = press || powered;
	// Subordinate holds not-ready until its modules are active
	assign NOT_READY_OUT = powered && (state_r == ST_NOT_READY);
	assign STATUS_STEADY = state_r == ST_RUN;
	assign CTRL_BOOT = state_r == ST_RUN && is_master_r && emb_s;
	assign PORT1_UPSTREAM = powered && is_master_r;
	assign PORT2_DOWNSTREAM = powered && is_master_r;

	////////////////////////////////////////////////////////////////////
	// Chain clock and cable detection
	logic in_clk_d_r, cable_ok_r, clk_run_r;
	logic [11:0] edge_to_r;
	logic [3:0] edge_cnt_r;
	logic [2:0] div_r;
	wire in_clk_edge = in_clk_s && !in_clk_d_r;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			in_clk_d_r <= 1'b0;
			edge_to_r <= 12'h000;
			edge_cnt_r <= 4'h0;
			cable_ok_r <= 1'b0;
			div_r <= 3'h0;
			clk_run_r <= 1'b0;
		end else begin
			in_clk_d_r <= in_clk_s;
			// Hot plug: cable counts once steady edges arrive
			if (!cable_s || edge_to_r == CABLE_TIMEOUT_CYC) begin
				edge_cnt_r <= 4'h0;
				cable_ok_r <= 1'b0;
				edge_to_r <= 12'h000;
			end else if (in_clk_edge) begin
				edge_to_r <= 12'h000;
				if (edge_cnt_r == CABLE_EDGES_NEEDED) cable_ok_r <= 1'b1;
				else edge_cnt_r <= edge_cnt_r + 4'h1;
			end else begin
				edge_to_r <= edge_to_r + 12'h001;
			end
			div_r <= div_r == 3'h4 ? 3'h0 : div_r + 3'h1;
			clk_run_r <= powered;
		end
	end
	assign CLOCK_FROM_CABLE = cable_ok_r && !is_master_r;
	// Own 100 MHz reference, else the cable clock forwarded when CLOCK_FROM_CABLE
	wire local_clk = div_r < 3'h2 || div_r == 3'h3 ? 1'b0 : 1'b1;
	logic out_clk_r;
	always_ff @(posedge CORE_CLK) begin
		if (RST) out_clk_r <= 1'b0;
		else out_clk_r <= CLOCK_FROM_CABLE ? in_clk_s : local_clk;
	end
	assign OUTBOUND_CHAIN_CLOCK = out_clk_r;
	assign OUTBOUND_CHAIN_RUN = clk_run_r;

	////////////////////////////////////////////////////////////////////
	// Sync distribution with hop delay compensation
	logic [63:0] sync_line_r;
	logic sync_out_r;
	wire sync_src = sync_drive ? LOCAL_SYNC : in_sync_s;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			sync_line_r <= 64'h0;
			sync_out_r <= 1'b0;
		end else begin
			sync_line_r <= {sync_line_r[62:0], sync_src};
			// Local copy delayed to line up with chassis downstream
			sync_out_r <= sync_drive ? sync_line_r[hop_r] : in_sync_s;
		end
	end
	assign CHASSIS_SYNC = sync_out_r;

	////////////////////////////////////////////////////////////////////
	// Flag lines
	logic [FLAG_COUNT-1:0] flag_out_r, flag_oe_r, refused;
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			flag_out_r <= '0;
			flag_oe_r <= '0;
		end else begin
			for (int i = 0; i < FLAG_COUNT; i++) begin
				case (flag_cfg_r[2*i +: 2])
					FLAG_MODE_STATIC0: begin
						flag_out_r[i] <= 1'b0;
						flag_oe_r[i] <= !other_drv_s[i];
					end
					FLAG_MODE_STATIC1: begin
						flag_out_r[i] <= 1'b1;
						flag_oe_r[i] <= !other_drv_s[i];
					end
					FLAG_MODE_SOURCE: begin
						flag_out_r[i] <= FLAG_SOURCE[i];
						flag_oe_r[i] <= !other_drv_s[i];
					end
					default: begin
						flag_out_r[i] <= 1'b0;
						flag_oe_r[i] <= 1'b0;
					end
				endcase
			end
		end
	end
	always_comb begin
		for (int i = 0; i < FLAG_COUNT; i++)
			refused[i] = flag_cfg_r[2*i +: 2] != FLAG_MODE_OFF
				&& other_drv_s[i];
	end
	assign FLAG_OUT = flag_out_r;
	assign FLAG_OE = flag_oe_r;
	assign FLAG_TO_TRIGGER = in_flag_s;

	////////////////////////////////////////////////////////////////////
	// Events and readback
	logic cable_d_r;
	always_ff @(posedge CORE_CLK) begin
		if (RST) cable_d_r <= 1'b0;
		else cable_d_r <= cable_ok_r;
	end
	always_comb begin
		ev_set = '0;
		ev_set[EV_POWER_ON] = state_r == ST_OFF && state_nxt == ST_NOT_READY;
		ev_set[EV_ALL_READY] = state_r == ST_WAIT_PEERS
			&& state_nxt == ST_DELAY;
		ev_set[EV_BOOT] = state_r != ST_RUN && state_nxt == ST_RUN;
		ev_set[EV_CABLE_IN] = cable_ok_r && !cable_d_r;
		ev_set[EV_CABLE_OUT] = !cable_ok_r && cable_d_r;
		ev_set[EV_FLAG_REFUSED] = |refused;
		ev_set[EV_WAIT_RESTART] = state_r == ST_DELAY
			&& state_nxt == ST_WAIT_PEERS;
	end
	wire [31:0] status_w = {20'h0, refused, CLOCK_FROM_CABLE, is_master_r,
		STATUS_STEADY, NOT_READY_OUT, 1'b0, state_r};
	always_comb begin
		case (ADDR)
			REG_CONTROL: rdata_nxt = control_r;
			REG_STATUS: rdata_nxt = status_w;
			REG_DELAY: rdata_nxt = delay_r;
			REG_FLAG_CFG: rdata_nxt = {24'h0, flag_cfg_r};
			REG_EVENT: rdata_nxt = {25'h0, event_r};
			REG_MASK: rdata_nxt = {25'h0, mask_r};
			REG_HOP: rdata_nxt = {26'h0, hop_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end
endmodule // mcpc_top
`default_nettype wire

/* File: hdl/mcpc_pkg.sv */
/*
 Constants for the multichassis power and flag coordination block.
 Assumes a 250 MHz core clock; all counts are in core clock cycles.
*/
package mcpc_pkg;
	localparam int CORE_CLK_MHZ = 250;
	localparam int FLAG_COUNT = 4;
	// Flag line modes
	localparam logic [1:0] FLAG_MODE_OFF = 2'h0;
	localparam logic [1:0] FLAG_MODE_STATIC0 = 2'h1;
	localparam logic [1:0] FLAG_MODE_STATIC1 = 2'h2;
	localparam logic [1:0] FLAG_MODE_SOURCE = 2'h3;
	// Startup delay unit and default figure
	localparam int STARTUP_DELAY_US = 1000;
	localparam int CYCLES_PER_US = CORE_CLK_MHZ;
	localparam logic [31:0] STARTUP_DELAY_CYC_DEF =
		32'(STARTUP_DELAY_US * CYCLES_PER_US);
	// Chain clock: 100 MHz shared clock from a 250 MHz core by 5/2 pattern
	localparam int CHAIN_CLK_MHZ = 100;
	localparam int HOP_DELAY_NS = 35;
	localparam int CAL_ERROR_PS = 600;
	localparam int CORE_PERIOD_PS = 1000000 / (CORE_CLK_MHZ * 1000) * 1000;
	localparam int HOP_DELAY_CYC = (HOP_DELAY_NS * 1000) / 4000;
	localparam logic [5:0] HOP_DELAY_CYC_DEF = 6'(HOP_DELAY_CYC);
	// Cable clock detect: edges must keep arriving within this window
	localparam int CABLE_TIMEOUT_NS = 1000;
	localparam logic [11:0] CABLE_TIMEOUT_CYC =
		12'((CABLE_TIMEOUT_NS * CORE_CLK_MHZ) / 1000);
	localparam logic [3:0] CABLE_EDGES_NEEDED = 4'h8;
	// Button press debounce for the power button input
	localparam int BUTTON_DEBOUNCE_US = 10;
	localparam logic [11:0] BUTTON_DEBOUNCE_CYC =
		12'(BUTTON_DEBOUNCE_US * CYCLES_PER_US);
	// Interrupt event bit positions
	localparam int EV_POWER_ON = 0;
	localparam int EV_ALL_READY = 1;
	localparam int EV_BOOT = 2;
	localparam int EV_CABLE_IN = 3;
	localparam int EV_CABLE_OUT = 4;
	localparam int EV_FLAG_REFUSED = 5;
	localparam int EV_WAIT_RESTART = 6;
	localparam int EV_COUNT = 7;
	// Register offsets (byte addresses, byte address = index * 4)
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DELAY = 8'h08;
	localparam logic [7:0] REG_FLAG_CFG = 8'h0C;
	localparam logic [7:0] REG_EVENT = 8'h10;
	localparam logic [7:0] REG_MASK = 8'h14;
	localparam logic [7:0] REG_HOP = 8'h18;
	// Control fields
	localparam int CTL_SYNC_DRIVE = 0;
	localparam int CTL_SW_POWER = 1;
	localparam int CTL_SW_OFF = 2;
	// Reset values
	localparam logic [31:0] CONTROL_RST = 32'h0000_0001;
	localparam logic [7:0] FLAG_CFG_RST = 8'h00;
	localparam logic [7:0] FLAG_SRC_RST = 8'h00;
	localparam logic [EV_COUNT-1:0] MASK_RST = '0;
endpackage

/* File: hdl/mcpc_sync2.sv */
/*
 Two-flop synchroniser bank for asynchronous pins.
 Assumes inputs are from outside the core clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module mcpc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // mcpc_sync2
`default_nettype wire

/* File: sim/mcpc_top_asserts.sv */
/*
 Port checker for the chassis coordination block.
 Assumes it is bound to mcpc_top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module mcpc_top_asserts
	import mcpc_pkg::*;
#(
	parameter logic [31:0] STARTUP_DELAY_CYC = STARTUP_DELAY_CYC_DEF
) (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic IRQ,
	input wire logic POWER_ON,
	input wire logic POWER_REQ_OUT,
	input wire logic NOT_READY_OUT,
	input wire logic PEER_NOT_READY_IN,
	input wire logic PORT1_UPSTREAM,
	input wire logic PORT2_DOWNSTREAM,
	input wire logic CTRL_BOOT,
	input wire logic STATUS_STEADY,
	input wire logic CLOCK_FROM_CABLE,
	input wire logic [FLAG_COUNT-1:0] INBOUND_CHAIN_FLAG,
	input wire logic [FLAG_COUNT-1:0] FLAG_OE,
	input wire logic [FLAG_COUNT-1:0] FLAG_OTHER_DRIVER,
	input wire logic [FLAG_COUNT-1:0] FLAG_TO_TRIGGER
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////////////////////////////////////
	// Cycles since any peer last showed not-ready or POWER_ON was low
	logic [31:0] quiet_r;
	logic [31:0] quiet_nxt;
	assign quiet_nxt = (PEER_NOT_READY_IN || !POWER_ON) ? 32'h0 :
		(quiet_r == 32'hFFFF_FFFF ? quiet_r : quiet_r + 32'h1);
	always_ff @(posedge CORE_CLK) begin
		quiet_r <= RST ? 32'h0 : quiet_nxt;
	end
	////////////////////////////////////////////////////////////////////////
	AST_REQ_WHILE_ON: assert property (POWER_ON |-> POWER_REQ_OUT)
		else $error("power request missing while powered");
	AST_NOT_READY_POWERED: assert property (NOT_READY_OUT |-> POWER_ON)
		else $error("not-ready shown while unpowered");
	AST_STEADY_READY: assert property (STATUS_STEADY |-> !NOT_READY_OUT)
		else $error("steady while still not ready");
	AST_DELAY_KEPT: assert property ($rose(STATUS_STEADY) && PORT1_UPSTREAM
		|-> quiet_r >= STARTUP_DELAY_CYC)
		else $error("master ran before the startup delay");
	AST_BOOT_AFTER: assert property (CTRL_BOOT |-> STATUS_STEADY)
		else $error("boot signalled outside run");
	AST_PORT_PAIR: assert property (PORT1_UPSTREAM == PORT2_DOWNSTREAM)
		else $error("host ports set up apart");
	AST_CABLE_SUB: assert property (CLOCK_FROM_CABLE |-> !PORT1_UPSTREAM)
		else $error("master took the cable clock");
	AST_FLAG_SYNC: assert property ($stable(INBOUND_CHAIN_FLAG) [*4]
		|-> FLAG_TO_TRIGGER == INBOUND_CHAIN_FLAG)
		else $error("inbound flag not passed to trigger");
	AST_ONE_SOURCE: assert property (($past(FLAG_OTHER_DRIVER, 4) &
		$past(FLAG_OTHER_DRIVER, 3) & $past(FLAG_OTHER_DRIVER, 2) &
		$past(FLAG_OTHER_DRIVER) & FLAG_OTHER_DRIVER & FLAG_OE) == 4'h0)
		else $error("second flag source not refused");
	C_RUN: cover property ($rose(STATUS_STEADY));
	C_BOOT: cover property ($rose(CTRL_BOOT));
	C_CABLE: cover property ($rose(CLOCK_FROM_CABLE));
	C_IRQ: cover property ($rose(IRQ));
endmodule // mcpc_top_asserts
bind mcpc_top mcpc_top_asserts #(.STARTUP_DELAY_CYC(STARTUP_DELAY_CYC)) i_chk (.*);
`default_nettype wire

/* File: sim/mcpc_peer_model.sv */
/*
 Neighbouring chassis: power link, not-ready, chain cable and flags.
 Assumes the bench steers its press, busy time and flag drive.
*/
`timescale 1ns/10ps
`default_nettype none
module mcpc_peer_model
	import mcpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_from_dut,
	input wire logic press,
	input wire logic hold_busy,
	input wire logic [7:0] ready_dly,
	input wire logic cable,
	input wire logic [FLAG_COUNT-1:0] drive_en,
	input wire logic [FLAG_COUNT-1:0] drive_val,
	input wire logic [FLAG_COUNT-1:0] dut_out,
	input wire logic [FLAG_COUNT-1:0] dut_oe,
	output logic power_req,
	output logic not_ready,
	output logic link_clk,
	output logic link_sync,
	output logic cable_present,
	output logic [FLAG_COUNT-1:0] flag_wire,
	output logic [FLAG_COUNT-1:0] other_drv
);
	logic powered_r;
	logic [7:0] cnt_r;
	assign power_req = press;
	assign cable_present = cable;
	assign other_drv = drive_en;
	// Lines bias low when nobody drives
	assign flag_wire = (drive_en & drive_val) | (dut_oe & dut_out);
	assign not_ready = powered_r && (hold_busy || cnt_r != ready_dly);
	always_ff @(posedge clk) begin
		if (rst) begin
			powered_r <= 1'h0;
			cnt_r <= 8'h00;
		end else begin
			powered_r <= powered_r || req_from_dut || press;
			cnt_r <= (powered_r && cnt_r != ready_dly) ? cnt_r + 8'h01 : cnt_r;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Cable clock stands still while unplugged
	initial link_clk = 1'h0;
	initial link_sync = 1'h0;
	always #62.5 link_clk = cable ? !link_clk : link_clk;
	always @(posedge link_clk) link_sync <= !link_sync;
endmodule // mcpc_peer_model
`default_nettype wire

/* File: sim/testbench.sv */
/*
 Self-checking bench for the chassis coordination block.
 Assumes a 250 MHz core clock and a short startup delay parameter.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mcpc_pkg::*;
	localparam logic [31:0] DLY = 32'h0000_0014;
	logic CORE_CLK = 1'h0, RST = 1'h1, WR = 1'h0, RD = 1'h0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0, RDATA, cfg;
	logic POWER_BUTTON = 1'h0, MODULES_ACTIVE = 1'h0, LOCAL_SYNC = 1'h0;
	logic EMBEDDED_CTRL_PRESENT = 1'h1, HOST_PORT1_CONNECTED = 1'h1;
	logic press = 1'h0, busy = 1'h0, cable = 1'h0;
	logic [3:0] FLAG_SOURCE = 4'h0, den = 4'h0, dval = 4'h0;
	logic [3:0] INBOUND_CHAIN_FLAG, FLAG_OUT, FLAG_OE, FLAG_OTHER_DRIVER;
	logic [3:0] FLAG_TO_TRIGGER;
	logic IRQ, POWER_REQ_IN, POWER_REQ_OUT, POWER_ON, PEER_NOT_READY_IN;
	logic NOT_READY_OUT, PORT1_UPSTREAM, PORT2_DOWNSTREAM, CTRL_BOOT;
	logic STATUS_STEADY, INBOUND_CHAIN_CLOCK, INBOUND_CHAIN_SYNC;
	logic CABLE_PRESENT, OUTBOUND_CHAIN_CLOCK, OUTBOUND_CHAIN_RUN;
	logic CLOCK_FROM_CABLE, CHASSIS_SYNC;
	int num_errors = 0, n_checks = 0, cyc = 0, n;
	always #2 CORE_CLK = !CORE_CLK;
	mcpc_top #(.STARTUP_DELAY_CYC(DLY)) i_dut (.*);
	mcpc_peer_model i_peer (.clk(CORE_CLK), .rst(RST),
		.req_from_dut(POWER_REQ_OUT), .press(press), .hold_busy(busy),
		.ready_dly(8'h10), .cable(cable), .drive_en(den), .drive_val(dval),
		.dut_out(FLAG_OUT), .dut_oe(FLAG_OE), .power_req(POWER_REQ_IN),
		.not_ready(PEER_NOT_READY_IN), .link_clk(INBOUND_CHAIN_CLOCK),
		.link_sync(INBOUND_CHAIN_SYNC), .cable_present(CABLE_PRESENT),
		.flag_wire(INBOUND_CHAIN_FLAG), .other_drv(FLAG_OTHER_DRIVER));
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'h1;
		@(posedge CORE_CLK);
		WR <= 1'h0;
	endtask
	task automatic check_reg(input string nm, input logic [7:0] a,
		input logic [31:0] e, input logic [31:0] m);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'h1;
		@(posedge CORE_CLK);
		RD <= 1'h0;
		#1;
		check(nm, e, RDATA & m);
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input string nm);
		for (n = 0; n < 4000 && s !== v; n++) @(posedge CORE_CLK);
		check(nm, {31'h0, v}, {31'h0, s});
	endtask
	function automatic logic [7:0] flag_exp(input logic [7:0] c,
		input logic [3:0] s, input logic [3:0] o);
		logic [3:0] oe, v;
		for (int i = 0; i < 4; i++) begin
			oe[i] = c[2*i +: 2] != FLAG_MODE_OFF && !o[i];
			v[i] = c[2*i +: 2] == FLAG_MODE_STATIC1 ||
				(c[2*i +: 2] == FLAG_MODE_SOURCE && s[i]);
		end
		return {oe, v & oe};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(23262));
		repeat (3) @(posedge CORE_CLK);
		RST <= 1'h0;
		wr_reg(8'h1C, 32'hFFFF_FFFF);
		check_reg("control", REG_CONTROL, CONTROL_RST, '1);
		check_reg("delay", REG_DELAY, DLY, '1);
		check_reg("hop", REG_HOP, 32'h8, '1);
		check_reg("flag cfg", REG_FLAG_CFG, 32'h0, '1);
		check_reg("unmapped", 8'h1C, 32'h0, '1);
		$display("reset values done");
		wr_reg(REG_MASK, 32'h7F);
		POWER_BUTTON <= 1'h1;
		wait_lvl(POWER_ON, 1'h1, "power on");
		POWER_BUTTON <= 1'h0;
		busy <= 1'h1;
		repeat (3) @(posedge CORE_CLK);
		check("not ready", 32'h3, {30'h0, NOT_READY_OUT, PEER_NOT_READY_IN});
		MODULES_ACTIVE <= 1'h1;
		repeat (40) @(posedge CORE_CLK);
		check("waits peers", 32'h0, {31'h0, STATUS_STEADY});
		busy <= 1'h0;
		repeat ($urandom_range(14, 5)) @(posedge CORE_CLK);
		busy <= 1'h1;
		repeat (3) @(posedge CORE_CLK);
		busy <= 1'h0;
		wait_lvl(STATUS_STEADY, 1'h1, "steady");
		check("delay length", 32'h1, {31'h0, n >= DLY && n <= DLY + 8});
		check("boot ports", 32'h7,
			{29'h0, CTRL_BOOT, PORT1_UPSTREAM, PORT2_DOWNSTREAM});
		check("irq", 32'h1, {31'h0, IRQ});
		check_reg("status", REG_STATUS, 32'h60, 32'hFF0);
		check_reg("events", REG_EVENT, 32'h47, 32'h7F);
		wr_reg(REG_EVENT, 32'h7F);
		check_reg("events clear", REG_EVENT, 32'h0, 32'h7F);
		check("irq clear", 32'h0, {31'h0, IRQ});
		cfg[0] = OUTBOUND_CHAIN_CLOCK;
		n = 0;
		repeat (50) begin
			@(posedge CORE_CLK);
			#1;
			n += OUTBOUND_CHAIN_CLOCK && !cfg[0];
			cfg[0] = OUTBOUND_CHAIN_CLOCK;
		end
		check("chain clock", CHAIN_CLK_MHZ * 200 / 1000, n);
		check("chain run", 32'h1, {31'h0, OUTBOUND_CHAIN_RUN});
		$display("master power up done");
		for (int k = 0; k < 10; k++) begin
			cfg = k == 0 ? 32'hE4 : $urandom();
			den <= k < 2 ? 4'h0 : 4'($urandom());
			dval <= 4'($urandom());
			FLAG_SOURCE <= 4'($urandom());
			LOCAL_SYNC <= 1'($urandom());
			wr_reg(REG_FLAG_CFG, {24'h0, cfg[7:0]});
			repeat (12) @(posedge CORE_CLK);
			check("sync", {31'h0, LOCAL_SYNC}, {31'h0, CHASSIS_SYNC});
			check("flags", {24'h0, flag_exp(cfg[7:0], FLAG_SOURCE, den)},
				{24'h0, FLAG_OE, FLAG_OUT & FLAG_OE});
			check("trigger", {28'h0, INBOUND_CHAIN_FLAG},
				{28'h0, FLAG_TO_TRIGGER});
		end
		den <= 4'h0;
		wr_reg(REG_EVENT, 32'h7F);
		$display("flag lines done");
		cable <= 1'h1;
		repeat (400) @(posedge CORE_CLK);
		check("master clock", 32'h0, {31'h0, CLOCK_FROM_CABLE});
		wr_reg(REG_CONTROL, 32'h5);
		repeat (4) @(posedge CORE_CLK);
		check("forced off", 32'h0, {31'h0, POWER_ON});
		EMBEDDED_CTRL_PRESENT <= 1'h0;
		wr_reg(REG_CONTROL, 32'h0);
		press <= 1'h1;
		wait_lvl(POWER_ON, 1'h1, "peer power on");
		press <= 1'h0;
		wait_lvl(STATUS_STEADY, 1'h1, "subordinate run");
		check("sub role", 32'h0, {30'h0, PORT1_UPSTREAM, CTRL_BOOT});
		wait_lvl(CLOCK_FROM_CABLE, 1'h1, "cable clock");
		@(INBOUND_CHAIN_SYNC);
		repeat (5) @(posedge CORE_CLK);
		check("chained sync", {31'h0, INBOUND_CHAIN_SYNC},
			{31'h0, CHASSIS_SYNC});
		cable <= 1'h0;
		wait_lvl(CLOCK_FROM_CABLE, 1'h0, "cable gone");
		check_reg("cable events", REG_EVENT, 32'h18, 32'h18);
		wr_reg(REG_MASK, 32'h0);
		#1;
		check("irq masked", 32'h0, {31'h0, IRQ});
		wr_reg(REG_MASK, 32'h8);
		#1;
		check("irq unmasked", 32'h1, {31'h0, IRQ});
		$display("subordinate and cable done");
		stop_test();
	end
endmodule // testbench
`default_nettype wire
